// File: design/cga_regs.svh
/*
 * Register offsets, reset values and fixed-point constants of the colour and gain adjust stage.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef CGA_REGS_SVH
`define CGA_REGS_SVH

// subaddresses of the adjustment registers
`define CGA_HUE_OFS 8'h1A
`define CGA_SAT_OFS 8'h1B
`define CGA_CGAIN_OFS 8'h1C
`define CGA_VGAIN_OFS 8'h1D

// reset values
`define CGA_HUE_RST 8'h00
`define CGA_SAT_RST 8'h80
`define CGA_CGAIN_RST 8'h40
`define CGA_VGAIN_RST 8'h80

// hue: bit 7 is the sign, bits 6:0 the magnitude (7F = 30 degrees)
`define CGA_HUE_SIGN 7
`define CGA_ROT_FRAC 12
`define CGA_ROT_ONE 14'h1000
`define CGA_SIN_SHIFT 4
`define CGA_COS_K 20'h00023
`define CGA_COS_SHIFT 10

// saturation is a Q1.7 factor, colour gain a Q2.6 factor
`define CGA_SAT_FRAC 7
`define CGA_SAT_UNITY 8'h80
`define CGA_CGAIN_FRAC 6
`define CGA_CGAIN_UNITY 8'h40
`define CGA_CGAIN_MIN 8'h20

// video gain: Q2.8 factor derived from the code, larger code gives lower gain
`define CGA_VG_FRAC 8
`define CGA_VG_NUM 16'h6700
`define CGA_VG_CODE_LO 8'h33
`define CGA_VG_CODE_HI 8'hCE
`define CGA_VG_GAIN_MAX 10'h1FD
`define CGA_VG_GAIN_MIN 10'h080
`define CGA_VG_UNITY 10'h100

// pixel pipeline depth in clock cycles
`define CGA_LATENCY 4

`endif

// File: design/cga_pkg.sv
/*
 * Types shared by the colour and gain adjust stage.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cga_pkg;

	// one 4:4:4 sample: unsigned luma, two's complement colour difference
	typedef struct packed {
		logic [7:0] y;
		logic signed [7:0] cb;
		logic signed [7:0] cr;
	} cga_pix_s;

	// byte write from the serial control bus front end
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} cga_wr_s;

	// Q2.8 video gain factor
	typedef logic [9:0] cga_vgain_t;

endpackage

// File: design/cga_scaler.sv
/*
 * Registered signed scaler: dout = saturate(din * gain >> FRAC).
 * Assumes clk and rstn of the pixel domain and an unsigned gain.
 */
`timescale 1ns/1ps

module cga_scaler #(
	parameter int W = 8,
	parameter int GW = 8,
	parameter int FRAC = 7
) (
	input wire logic clk, // pixel clock
	input wire logic rstn, // async reset, active low
	input wire logic signed [W-1:0] din, // sample in
	input wire logic [GW-1:0] gain, // unsigned fixed-point gain
	output logic signed [W-1:0] dout // scaled, saturated sample
);
	localparam int PW = W + GW + 1;
	localparam logic signed [PW-1:0] MAXV = PW'((64'sd1 <<< (W - 1)) - 64'sd1);
	localparam logic signed [PW-1:0] MINV = PW'(-(64'sd1 <<< (W - 1)));

	logic signed [PW-1:0] prod;
	logic signed [PW-1:0] shifted;

	assign prod = PW'(din) * $signed({1'b0, gain});
	assign shifted = prod >>> FRAC;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dout <= '0;
		end else if (shifted > MAXV) begin
			dout <= MAXV[W-1:0];
		end else if (shifted < MINV) begin
			dout <= MINV[W-1:0];
		end else begin
			dout <= shifted[W-1:0];
		end
	end

endmodule

// File: design/cga_color_gain.sv
/*
 * Colour and gain adjust stage: video gain, hue rotation, saturation and colour gain.
 * Assumes register writes arrive from the control bus front end in the pixel clock domain,
 * and that the gain-mode selects and automatic gain values come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "cga_regs.svh"

module cga_color_gain
	import cga_pkg::*;
(
	input wire logic clk, // pixel clock, 100 MHz
	input wire logic rstn, // async reset, active low
	input wire cga_wr_s reg_wr, // register write strobe, subaddress and data
	input wire logic [7:0] reg_rd_addr, // subaddress for read back
	output logic [7:0] reg_rdata, // read data, one cycle after the address
	input wire logic chroma_fixed_gain, // colour processing selects fixed gain
	input wire logic video_fixed_gain, // analog input control selects fixed gain
	input wire logic [7:0] agc_chroma_gain, // automatic colour gain, Q2.6
	input wire logic [7:0] agc_video_code, // automatic video gain code
	input wire logic pix_in_valid, // input sample valid
	input wire cga_pix_s pix_in, // input sample
	output logic pix_out_valid, // output sample valid
	output cga_pix_s pix_out // adjusted sample
);
	logic [7:0] hue_r;
	logic [7:0] sat_r;
	logic [7:0] cgain_r;
	logic [7:0] vgain_r;

	logic [7:0] eff_vcode;
	cga_vgain_t vgain_q;
	logic [7:0] eff_cgain;

	logic signed [8:0] y1_s;
	logic signed [7:0] c1 [2];
	logic signed [7:0] c2 [2];
	logic signed [7:0] c3 [2];
	logic signed [7:0] c4 [2];
	logic [7:0] y2_r;
	logic [7:0] y3_r;
	logic [7:0] y4_r;
	logic [`CGA_LATENCY-1:0] vld_r;

	logic [6:0] hue_mag;
	logic [19:0] hue_sq;
	logic signed [13:0] sin_q;
	logic signed [13:0] cos_q;
	logic signed [22:0] rot_cb;
	logic signed [22:0] rot_cr;

	// maps a video gain code to a Q2.8 factor, inverse in the code
	function automatic cga_vgain_t vgain_lookup(input logic [7:0] code);
		logic [15:0] q;
		q = '0;
		if (code <= `CGA_VG_CODE_LO) begin
			vgain_lookup = `CGA_VG_GAIN_MAX;
		end else if (code >= `CGA_VG_CODE_HI) begin
			vgain_lookup = `CGA_VG_GAIN_MIN;
		end else begin
			q = `CGA_VG_NUM / {8'h00, code};
			vgain_lookup = q[9:0];
		end
	endfunction

	function automatic logic signed [7:0] sat8(input logic signed [22:0] v);
		if (v > 23'sd127) begin
			sat8 = 8'sh7F;
		end else if (v < -23'sd128) begin
			sat8 = 8'sh80;
		end else begin
			sat8 = v[7:0];
		end
	endfunction

	// register writes; settings are read live by each pipeline stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hue_r <= `CGA_HUE_RST;
			sat_r <= `CGA_SAT_RST;
			cgain_r <= `CGA_CGAIN_RST;
			vgain_r <= `CGA_VGAIN_RST;
		end else if (reg_wr.en) begin
			if (reg_wr.addr == `CGA_HUE_OFS) begin
				hue_r <= reg_wr.data;
			end else if (reg_wr.addr == `CGA_SAT_OFS) begin
				sat_r <= reg_wr.data;
			end else if (reg_wr.addr == `CGA_CGAIN_OFS) begin
				cgain_r <= reg_wr.data;
			end else if (reg_wr.addr == `CGA_VGAIN_OFS) begin
				vgain_r <= reg_wr.data;
			end
		end
	end

	// read back; other subaddresses belong to other blocks and read zero here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd_addr == `CGA_HUE_OFS) begin
			reg_rdata <= hue_r;
		end else if (reg_rd_addr == `CGA_SAT_OFS) begin
			reg_rdata <= sat_r;
		end else if (reg_rd_addr == `CGA_CGAIN_OFS) begin
			reg_rdata <= cgain_r;
		end else if (reg_rd_addr == `CGA_VGAIN_OFS) begin
			reg_rdata <= vgain_r;
		end else begin
			reg_rdata <= '0;
		end
	end

	// stage 1: combined video gain on luma and both chroma channels
	assign eff_vcode = video_fixed_gain ? vgain_r : agc_video_code;
	assign vgain_q = vgain_lookup(eff_vcode);

	cga_scaler #(.W(9), .GW(10), .FRAC(`CGA_VG_FRAC)) u_vg_y (
		.clk(clk),
		.rstn(rstn),
		.din($signed({1'b0, pix_in.y})),
		.gain(vgain_q),
		.dout(y1_s)
	);

	cga_scaler #(.W(8), .GW(10), .FRAC(`CGA_VG_FRAC)) u_vg_cb (
		.clk(clk),
		.rstn(rstn),
		.din(pix_in.cb),
		.gain(vgain_q),
		.dout(c1[0])
	);

	cga_scaler #(.W(8), .GW(10), .FRAC(`CGA_VG_FRAC)) u_vg_cr (
		.clk(clk),
		.rstn(rstn),
		.din(pix_in.cr),
		.gain(vgain_q),
		.dout(c1[1])
	);

	// stage 2: hue rotation, sign-magnitude angle, chordal sine and quadratic cosine
	assign hue_mag = hue_r[6:0];
	assign hue_sq = 20'(hue_mag) * 20'(hue_mag) * `CGA_COS_K;
	assign cos_q = $signed(14'(`CGA_ROT_ONE - 14'(hue_sq >> `CGA_COS_SHIFT)));
	assign sin_q = hue_r[`CGA_HUE_SIGN] ? -$signed({3'b000, hue_mag, 4'h0}) : $signed({3'b000, hue_mag, 4'h0});
	assign rot_cb = (23'(c1[0]) * 23'(cos_q) - 23'(c1[1]) * 23'(sin_q)) >>> `CGA_ROT_FRAC;
	assign rot_cr = (23'(c1[1]) * 23'(cos_q) + 23'(c1[0]) * 23'(sin_q)) >>> `CGA_ROT_FRAC;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			c2[0] <= '0;
			c2[1] <= '0;
		end else begin
			c2[0] <= sat8(rot_cb);
			c2[1] <= sat8(rot_cr);
		end
	end

	// stages 3 and 4: saturation, then colour gain, per chroma channel
	assign eff_cgain = chroma_fixed_gain ? ((cgain_r < `CGA_CGAIN_MIN) ? `CGA_CGAIN_MIN : cgain_r)
		: ((agc_chroma_gain < `CGA_CGAIN_MIN) ? `CGA_CGAIN_MIN : agc_chroma_gain);

	for (genvar i = 0; i < 2; i++) begin : g_chroma
		cga_scaler #(.W(8), .GW(8), .FRAC(`CGA_SAT_FRAC)) u_sat (
			.clk(clk),
			.rstn(rstn),
			.din(c2[i]),
			.gain(sat_r),
			.dout(c3[i])
		);
		cga_scaler #(.W(8), .GW(8), .FRAC(`CGA_CGAIN_FRAC)) u_cg (
			.clk(clk),
			.rstn(rstn),
			.din(c3[i]),
			.gain(eff_cgain),
			.dout(c4[i])
		);
	end

	// luma follows chroma through the rotation and chroma gain stages
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			y2_r <= '0;
			y3_r <= '0;
			y4_r <= '0;
		end else begin
			y2_r <= y1_s[7:0];
			y3_r <= y2_r;
			y4_r <= y3_r;
		end
	end

	// fixed latency whatever the settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vld_r <= '0;
		end else begin
			vld_r <= {vld_r[`CGA_LATENCY-2:0], pix_in_valid};
		end
	end

	assign pix_out_valid = vld_r[`CGA_LATENCY-1];
	assign pix_out = '{y: y4_r, cb: c4[0], cr: c4[1]};

	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_hue_sign: assert property (hue_mag != 7'h00 |-> (hue_r[7] ? sin_q < 0 : sin_q > 0) && cos_q <= 14'sh1000)
		else $error("hue sine sign or cosine wrong");
	a_hue_full: assert property (hue_mag == 7'h7F |-> (sin_q == 14'sd2032 || sin_q == -14'sd2032))
		else $error("hue at full scale is not thirty degrees");
	a_hue_bypass: assert property (hue_mag == 7'h00 |=> c2[0] == $past(c1[0]) && c2[1] == $past(c1[1]))
		else $error("zero hue altered chroma");
	a_sat_unity: assert property (sat_r == `CGA_SAT_UNITY |=> c3[0] == $past(c2[0]) && c3[1] == $past(c2[1]))
		else $error("unity saturation altered chroma");
	a_sat_mono: assert property (sat_r == 8'h00 |=> c3[0] == 8'sh00 && c3[1] == 8'sh00)
		else $error("zero saturation left colour");
	a_sat_double: assert property (sat_r == 8'hFF && c2[0] > 8'sh00 && c2[0] < 8'sh40
		|=> c3[0] == 8'(2 * $past(c2[0]) - 1))
		else $error("full saturation factor wrong");
	a_cgain_floor: assert property (eff_cgain >= `CGA_CGAIN_MIN)
		else $error("colour gain below half");
	a_cgain_unity: assert property (eff_cgain == `CGA_CGAIN_UNITY |=> c4[1] == $past(c3[1]))
		else $error("unity colour gain altered data");
	a_cgain_mode: assert property (!chroma_fixed_gain && agc_chroma_gain >= `CGA_CGAIN_MIN
		|-> eff_cgain == agc_chroma_gain)
		else $error("colour gain register used outside fixed mode");
	a_vgain_mode: assert property ((video_fixed_gain && vgain_r == 8'h80)
		|| (!video_fixed_gain && agc_video_code == 8'h80) |-> vgain_q == 10'h0CE)
		else $error("video gain source wrong");
	a_vgain_shared: assert property (vgain_q == `CGA_VG_UNITY && pix_in.y < 8'h80
		|=> y1_s[7:0] == $past(pix_in.y) && c1[0] == $past(pix_in.cb))
		else $error("unity video gain not shared by luma and chroma");
	a_vgain_ends: assert property ((eff_vcode == `CGA_VG_CODE_HI |-> vgain_q == `CGA_VG_GAIN_MIN)
		and (eff_vcode == `CGA_VG_CODE_LO |-> vgain_q == `CGA_VG_GAIN_MAX))
		else $error("video gain end points wrong");
	a_vgain_order: assert property (eff_vcode > 8'h33 && eff_vcode < 8'hCE |-> vgain_q >= 10'h080 && vgain_q <= 10'h1FD)
		else $error("video gain out of range");
	a_out_latency: assert property (pix_in_valid |-> ##4 pix_out_valid)
		else $error("output timing disturbed");
	a_out_idle: assert property (!pix_in_valid |-> ##4 !pix_out_valid)
		else $error("spurious output valid");

	// rotation coefficients at zero angle and over the whole thirty degree range
	a_hue_coef_zero: assert property (hue_mag == 7'h00 |-> sin_q == 14'sh0000 && cos_q == 14'sh1000)
		else $error("zero hue coefficients not identity");
	a_hue_cos_range: assert property (cos_q <= 14'sh1000 && cos_q >= 14'sh0D00)
		else $error("hue cosine beyond thirty degrees");

	// saturation keeps the sign and direction of each colour sample
	a_sat_grow: assert property (sat_r >= `CGA_SAT_UNITY && c2[0] > 8'sh00 |=> c3[0] >= $past(c2[0]))
		else $error("saturation above unity shrank colour");
	a_sat_shrink: assert property (sat_r <= `CGA_SAT_UNITY && c2[1] < 8'sh00
		|=> c3[1] <= 8'sh00 && c3[1] >= $past(c2[1]))
		else $error("saturation below unity grew colour");

	// colour gain end points and source
	a_cgain_half: assert property (eff_cgain == `CGA_CGAIN_MIN |=> c4[0] == ($past(c3[0]) >>> 1))
		else $error("half colour gain wrong");
	a_cgain_max: assert property (eff_cgain == 8'hFF && c3[0] > 8'sh00 && c3[0] < 8'sh20
		|=> c4[0] == 8'(4 * $past(c3[0]) - 1))
		else $error("full colour gain wrong");
	a_cgain_fixed: assert property (chroma_fixed_gain && cgain_r >= `CGA_CGAIN_MIN |-> eff_cgain == cgain_r)
		else $error("fixed mode ignores colour gain register");
	a_cgain_clamp: assert property (chroma_fixed_gain && cgain_r < `CGA_CGAIN_MIN
		|-> eff_cgain == `CGA_CGAIN_MIN)
		else $error("colour gain below half not clamped");

	// video gain lookup points and their effect on both channels
	a_vgain_unity: assert property (eff_vcode == 8'h67 |-> vgain_q == `CGA_VG_UNITY)
		else $error("video gain code 67 not unity");
	a_vgain_mid: assert property (eff_vcode == 8'h99 |-> vgain_q == 10'h0AC)
		else $error("video gain code 99 wrong");
	a_vgain_half: assert property (vgain_q == `CGA_VG_GAIN_MIN
		|=> y1_s[7:0] == ($past(pix_in.y) >> 1) && c1[1] == ($past(pix_in.cr) >>> 1))
		else $error("half video gain not shared by luma and chroma");
	a_vgain_luma_sat: assert property (vgain_q == `CGA_VG_GAIN_MAX && pix_in.y > 8'h80
		|=> y1_s == 9'sh0FF)
		else $error("luma not saturated at full video gain");

	// settings change only by a write to their own subaddress
	a_wr_hue_sat: assert property (
		(reg_wr.en && reg_wr.addr == `CGA_HUE_OFS |=> hue_r == $past(reg_wr.data))
		and (reg_wr.en && reg_wr.addr == `CGA_SAT_OFS |=> sat_r == $past(reg_wr.data)))
		else $error("hue or saturation write lost");
	a_wr_gains: assert property (
		(reg_wr.en && reg_wr.addr == `CGA_CGAIN_OFS |=> cgain_r == $past(reg_wr.data))
		and (reg_wr.en && reg_wr.addr == `CGA_VGAIN_OFS |=> vgain_r == $past(reg_wr.data)))
		else $error("gain write lost");
	a_set_hold: assert property (!reg_wr.en || reg_wr.addr < `CGA_HUE_OFS || reg_wr.addr > `CGA_VGAIN_OFS
		|=> $stable(hue_r) && $stable(sat_r) && $stable(cgain_r) && $stable(vgain_r))
		else $error("setting changed without a write");

endmodule

// File: test/tb.sv
/*
 * Self-checking bench for the colour and gain adjust stage: register reset, write and read back,
 * pixel arithmetic per setting, gain-mode selection and fixed output latency.
 * Assumes the design files under design/ are compiled first and cga_regs.svh is on the include path.
 */
`timescale 1ns/1ps
`include "cga_regs.svh"

module tb
	import cga_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	cga_wr_s reg_wr;
	logic [7:0] reg_rd_addr;
	logic [7:0] reg_rdata;
	logic chroma_fixed_gain;
	logic video_fixed_gain;
	logic [7:0] agc_chroma_gain;
	logic [7:0] agc_video_code;
	logic pix_in_valid;
	cga_pix_s pix_in;
	logic pix_out_valid;
	cga_pix_s pix_out;
	cga_pix_s pats [4];
	int error_cnt = 0;
	int tests_run = 0;

	cga_color_gain dut (
		.clk(clk),
		.rstn(rstn),
		.reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr),
		.reg_rdata(reg_rdata),
		.chroma_fixed_gain(chroma_fixed_gain),
		.video_fixed_gain(video_fixed_gain),
		.agc_chroma_gain(agc_chroma_gain),
		.agc_video_code(agc_video_code),
		.pix_in_valid(pix_in_valid),
		.pix_in(pix_in),
		.pix_out_valid(pix_out_valid),
		.pix_out(pix_out)
	);

	always #5 clk = ~clk;

	task automatic finish_test;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= '{1'b1, a, d};
		@(posedge clk);
		reg_wr.en <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		reg_rd_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
	endtask

	function automatic int s8(int v);
		return (v > 127) ? 127 : ((v < -128) ? -128 : v);
	endfunction

	// reference arithmetic: video gain, hue rotation, saturation, colour gain
	function automatic cga_pix_s model(cga_pix_s p, logic [7:0] h, logic [7:0] s, logic [7:0] c, logic [7:0] vc);
		int g, y, cb, cr, m, sn, cs, b2, r2, sv, cv;
		g = (vc <= 8'h33) ? 509 : ((vc >= 8'hCE) ? 128 : 26368 / int'(vc));
		y = (int'(p.y) * g) >>> 8;
		y = (y > 255) ? 255 : y;
		cb = s8((int'(p.cb) * g) >>> 8);
		cr = s8((int'(p.cr) * g) >>> 8);
		m = int'(h[6:0]);
		sn = h[7] ? -m * 16 : m * 16;
		cs = 4096 - ((m * m * 35) >> 10);
		b2 = s8((cb * cs - cr * sn) >>> 12);
		r2 = s8((cr * cs + cb * sn) >>> 12);
		sv = int'(s);
		b2 = s8((b2 * sv) >>> 7);
		r2 = s8((r2 * sv) >>> 7);
		cv = (c < 8'h20) ? 32 : int'(c);
		b2 = s8((b2 * cv) >>> 6);
		r2 = s8((r2 * cv) >>> 6);
		return {y[7:0], b2[7:0], r2[7:0]};
	endfunction

	// program settings, then stream four pixels back to back and check each exactly four cycles later
	task automatic run(logic [7:0] h, logic [7:0] s, logic [7:0] cg, logic [7:0] vc, logic cf, logic vf);
		cga_pix_s e [4];
		logic [7:0] ec;
		logic [7:0] ev;
		wr(`CGA_HUE_OFS, h);
		wr(`CGA_SAT_OFS, s);
		wr(`CGA_CGAIN_OFS, cg);
		wr(`CGA_VGAIN_OFS, vc);
		@(posedge clk);
		chroma_fixed_gain <= cf;
		video_fixed_gain <= vf;
		ec = cf ? cg : agc_chroma_gain;
		ev = vf ? vc : agc_video_code;
		for (int i = 0; i < 4; i++)
			e[i] = model(pats[i], h, s, ec, ev);
		for (int j = 0; j < 10; j++) begin
			@(posedge clk);
			pix_in_valid <= (j < 4);
			pix_in <= pats[j % 4];
			#1;
			if (j >= 4 && j < 8)
				chk("pix_out", e[j-4], pix_out);
			chk("pix_out_valid", {23'h0, (j >= 4 && j < 8)}, {23'h0, pix_out_valid});
		end
	endtask

	initial begin
		#900000;
		error_cnt++;
		$display("[FAIL] watchdog expected end of run seen none");
		finish_test();
	end

	initial begin
		reg_wr = '0;
		reg_rd_addr = 8'h00;
		chroma_fixed_gain = 1'b1;
		video_fixed_gain = 1'b1;
		agc_chroma_gain = 8'h40;
		agc_video_code = 8'h80;
		pix_in_valid = 1'b0;
		pix_in = '0;
		pats[0] = {8'h80, 8'h10, 8'hF0};
		pats[1] = {8'hFF, 8'h7F, 8'h80};
		pats[2] = {8'h10, 8'hC0, 8'h40};
		pats[3] = {8'h00, 8'h81, 8'h7F};
		repeat (5) @(posedge clk);
		#1;
		chk("pix_out reset", 24'h000000, pix_out);
		chk("pix_out_valid reset", 24'h000000, {23'h0, pix_out_valid});
		chk("reg_rdata reset", 24'h000000, {16'h0000, reg_rdata});
		@(posedge clk);
		rstn <= 1'b1;
		rd(`CGA_HUE_OFS, 8'h00);
		rd(`CGA_SAT_OFS, 8'h80);
		rd(`CGA_CGAIN_OFS, 8'h40);
		rd(`CGA_VGAIN_OFS, 8'h80);
		rd(8'h1E, 8'h00);
		wr(8'h1F, 8'h55);
		wr(`CGA_HUE_OFS, 8'h5A);
		wr(`CGA_SAT_OFS, 8'hA5);
		wr(`CGA_CGAIN_OFS, 8'h3C);
		wr(`CGA_VGAIN_OFS, 8'hC3);
		rd(8'h1F, 8'h00);
		rd(`CGA_HUE_OFS, 8'h5A);
		rd(`CGA_SAT_OFS, 8'hA5);
		rd(`CGA_CGAIN_OFS, 8'h3C);
		rd(`CGA_VGAIN_OFS, 8'hC3);
		run(8'h00, 8'h80, 8'h40, 8'h67, 1'b1, 1'b1);
		run(8'h7F, 8'h80, 8'h40, 8'h80, 1'b1, 1'b1);
		run(8'hFF, 8'h80, 8'h40, 8'h80, 1'b1, 1'b1);
		run(8'h15, 8'h00, 8'h40, 8'h80, 1'b1, 1'b1);
		run(8'h40, 8'hFF, 8'h40, 8'h80, 1'b1, 1'b1);
		run(8'h00, 8'h80, 8'h20, 8'h80, 1'b1, 1'b1);
		run(8'h00, 8'h80, 8'hFF, 8'h80, 1'b1, 1'b1);
		run(8'h00, 8'h80, 8'h10, 8'h80, 1'b1, 1'b1);
		run(8'h00, 8'h80, 8'h40, 8'h33, 1'b1, 1'b1);
		run(8'h00, 8'h80, 8'h40, 8'hCE, 1'b1, 1'b1);
		run(8'h00, 8'h80, 8'h40, 8'h99, 1'b1, 1'b1);
		run(8'h00, 8'h80, 8'hFF, 8'h80, 1'b0, 1'b1);
		run(8'h00, 8'h80, 8'h40, 8'h33, 1'b1, 1'b0);
		finish_test();
	end
endmodule
